// File: ffs_pkg.sv
package ffs_pkg;

  // Register numbers as seen in the command byte of a serial access.
  localparam logic [6:0] REG_FIFO_THR = 7'h28;
  localparam logic [6:0] REG_POL_CRC = 7'h29;
  localparam logic [6:0] REG_STATUS = 7'h30;
  localparam logic [6:0] REG_FIFO_DATA = 7'h32;
  localparam logic [6:0] REG_PTR_CTRL = 7'h34;

  // Field positions.
  localparam int POL_BIT = 10;
  localparam int CRC_SEED_LSB = 0;
  localparam int EMPTY_THR_LSB = 11;
  localparam int FULL_THR_LSB = 6;
  localparam int THR_W = 5;
  localparam int CLR_W_BIT = 15;
  localparam int CLR_R_BIT = 7;
  localparam int WR_POS_LSB = 8;
  localparam int RD_POS_LSB = 0;
  localparam int ST_CRC_BIT = 15;
  localparam int ST_FEC_BIT = 14;
  localparam int ST_STATE_LSB = 8;
  localparam int ST_SYNC_BIT = 7;
  localparam int ST_PKT_BIT = 6;
  localparam int ST_FIFO_BIT = 5;

  // Reset values and write mask.
  localparam logic [15:0] POL_CRC_RST = 16'hB800;
  localparam logic [15:0] FIFO_THR_RST = 16'h2107;
  localparam logic [15:0] POL_CRC_WMASK = 16'hFFFF;

  // Widths and depths.
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 64;
  localparam int POS_W = 6;

  // Serial access framing counts.
  localparam logic [3:0] CMD_LAST = 4'h7;
  localparam logic [3:0] BYTE_LAST = 4'h7;
  localparam logic [3:0] WORD_LAST = 4'hF;

  typedef struct packed {
    logic rd;
    logic [6:0] addr;
  } ffs_cmd_t;

  typedef struct packed {
    logic crc_error;
    logic fec_error;
    logic [5:0] framer_state;
    logic sync_found;
    logic packet_flag_mirror;
    logic tx_active;
    logic rx_active;
  } ffs_eng_stat_t;

  typedef enum logic [1:0] {
    ST_CMD,
    ST_DATA,
    ST_SKIP
  } ffs_spi_state_t;

endpackage

// File: ffs_sync.sv
`timescale 1ns/1ns
`default_nettype none

module ffs_sync #(
  parameter int W = 3
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [W-1:0] d_async,
  output logic [W-1:0] d_sync
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // The first stage feeds only the second stage of the same bit.
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          meta_q[i] <= 1'b0;
          sync_q[i] <= 1'b0;
        end else begin
          meta_q[i] <= d_async[i];
          sync_q[i] <= meta_q[i];
        end
      end
    end
  endgenerate

  assign d_sync = sync_q;

endmodule

`default_nettype wire

// File: ffs_fifo.sv
`timescale 1ns/1ns
`default_nettype none

module ffs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 64
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clr_wr,
  input wire logic clr_rd,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH)-1:0] wr_pos,
  output logic [$clog2(DEPTH)-1:0] rd_pos,
  output logic [$clog2(DEPTH):0] level
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_LEVEL = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  assign level = wr_q - rd_q;
  assign in_ready = (level != FULL_LEVEL);
  assign out_valid = (level != '0);
  assign out_data = mem_q[rd_q[AW-1:0]];
  assign wr_pos = wr_q[AW-1:0];
  assign rd_pos = rd_q[AW-1:0];

  // A clear overrides a move of the same pointer in that cycle.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (clr_wr) begin
        wr_q <= '0;
      end else if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (clr_rd) begin
        rd_q <= '0;
      end else if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end

endmodule

`default_nettype wire

// File: ffs_top.sv
`timescale 1ns/1ns
`default_nettype none

module ffs_top
  import ffs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic spi_ss_n,
  input wire logic spi_sck,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe_n,
  input wire ffs_pkg::ffs_eng_stat_t eng_stat,
  input wire logic eng_rx_valid,
  output logic eng_rx_ready,
  input wire logic [ffs_pkg::DATA_W-1:0] eng_rx_data,
  output logic eng_tx_valid,
  input wire logic eng_tx_ready,
  output logic [ffs_pkg::DATA_W-1:0] eng_tx_data,
  output logic [ffs_pkg::DATA_W-1:0] crc_seed,
  output logic packet_flag_mirror_pin,
  output logic fifo_flag_pin
);

  import ffs_pkg::*;

  // Serial pins come from the host's clock and are sampled here.
  logic ss_sel_s;
  logic sck_s;
  logic mosi_s;
  logic sck_d_q;

  ffs_sync #(
    .W(3)
  ) u_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .d_async({~spi_ss_n, spi_sck, spi_mosi}),
    .d_sync({ss_sel_s, sck_s, mosi_s})
  );

  // Select travels inverted, so a chain still at its reset value reads as deselected.
  wire ss_n_s = ~ss_sel_s;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sck_d_q <= 1'b0;
    end else begin
      sck_d_q <= sck_s;
    end
  end

  wire sck_rise = sck_s & ~sck_d_q & ~ss_n_s;
  wire sck_fall = ~sck_s & sck_d_q & ~ss_n_s;

  // Software registers.
  logic [15:0] pol_crc_q;
  logic [15:0] pol_crc_d;
  logic [15:0] fifo_thr_q;
  logic [15:0] fifo_thr_d;
  logic sync_seen_q;
  logic pkt_mirror_q;
  logic fifo_mirror_q;
  logic packet_flag_mirror_q;
  logic fifo_flag_q;

  // Serial access engine.
  ffs_spi_state_t state_q;
  ffs_spi_state_t state_d;
  ffs_cmd_t cmd_q;
  ffs_cmd_t cmd_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic [15:0] sh_in_q;
  logic [15:0] sh_out_q;
  logic [15:0] sh_out_d;
  logic hold_q;
  logic hold_d;
  logic reload_q;

  // FIFO connections.
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [DATA_W-1:0] fifo_in_data;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [DATA_W-1:0] fifo_out_data;
  logic [POS_W-1:0] wr_pos;
  logic [POS_W-1:0] rd_pos;
  logic [POS_W:0] level;

  function automatic logic addr_is(input ffs_cmd_t c, input logic [6:0] a);
    addr_is = (c.addr == a);
  endfunction

  wire [15:0] in_word = {sh_in_q[14:0], mosi_s};
  wire ffs_cmd_t cmd_now = ffs_cmd_t'(in_word[7:0]);
  wire rx_on = eng_stat.rx_active;
  wire tx_on = eng_stat.tx_active;

  // Unit length: one byte for the data port, one word elsewhere.
  // byte-wide data port
  wire data_is_fifo = addr_is(cmd_q, REG_FIFO_DATA);
  wire [3:0] data_last = data_is_fifo ? BYTE_LAST : WORD_LAST;
  wire cmd_done = sck_rise && (state_q == ST_CMD) && (cnt_q == CMD_LAST);
  wire data_done = sck_rise && (state_q == ST_DATA) && (cnt_q == data_last);
  wire wr_commit = data_done && !cmd_q.rd;

  wire wr_thr = wr_commit && addr_is(cmd_q, REG_FIFO_THR);
  wire wr_pol = wr_commit && addr_is(cmd_q, REG_POL_CRC);
  wire wr_ptr = wr_commit && addr_is(cmd_q, REG_PTR_CTRL);
  wire host_push = wr_commit && data_is_fifo;

  // A data port byte is popped once its last bit has gone out, so a cut frame loses nothing.
  wire next_fifo_rd = data_done && cmd_q.rd && data_is_fifo;
  wire host_pop = next_fifo_rd;
  wire [DATA_W-1:0] fifo_head = fifo_out_valid ? fifo_out_data : '0;

  wire clr_wr_pulse = wr_ptr && in_word[CLR_W_BIT] && !rx_on;
  wire clr_rd_pulse = wr_ptr && in_word[CLR_R_BIT] && !tx_on;

  // The engine owns the fill side in receive and the drain side in transmit;
  // host bytes that find the FIFO full are dropped, the serial bus cannot stall.
  assign fifo_in_valid = rx_on ? eng_rx_valid : host_push;
  assign fifo_in_data = rx_on ? eng_rx_data : in_word[DATA_W-1:0];
  assign eng_rx_ready = rx_on & fifo_in_ready;
  assign fifo_out_ready = tx_on ? eng_tx_ready : host_pop;
  assign eng_tx_valid = tx_on & fifo_out_valid;
  assign eng_tx_data = fifo_out_data;

  ffs_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .clr_wr(clr_wr_pulse),
    .clr_rd(clr_rd_pulse),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data),
    .wr_pos(wr_pos),
    .rd_pos(rd_pos),
    .level(level)
  );

  // FIFO flag: almost empty in transmit, almost full in receive.
  wire [THR_W-1:0] empty_thr = fifo_thr_q[EMPTY_THR_LSB +: THR_W];
  wire [THR_W-1:0] full_thr = fifo_thr_q[FULL_THR_LSB +: THR_W];
  wire tx_warn = tx_on && (level <= {2'b00, empty_thr});
  wire rx_warn = rx_on && (level >= {2'b00, full_thr});
  wire fifo_flag_raw = tx_warn | rx_warn;

  // Status and pointer words.
  wire [15:0] status_word;
  wire [15:0] ptr_word;
  assign status_word[ST_CRC_BIT] = eng_stat.crc_error;
  assign status_word[ST_FEC_BIT] = eng_stat.fec_error;
  assign status_word[ST_STATE_LSB +: 6] = eng_stat.framer_state;
  assign status_word[ST_SYNC_BIT] = sync_seen_q;
  assign status_word[ST_PKT_BIT] = pkt_mirror_q;
  assign status_word[ST_FIFO_BIT] = fifo_mirror_q;
  assign status_word[4:0] = 5'h00;
  // pointer readback, count of bytes waiting
  assign ptr_word = {2'b00, wr_pos, 2'b00, level[POS_W-1:0]};

  function automatic logic [15:0] read_mux(
    input ffs_cmd_t c,
    input logic [15:0] thr,
    input logic [15:0] pol,
    input logic [15:0] stat,
    input logic [15:0] ptr,
    input logic [DATA_W-1:0] head
  );
    read_mux = 16'h0000;
    if (addr_is(c, REG_FIFO_THR)) begin
      read_mux = thr;
    end else if (addr_is(c, REG_POL_CRC)) begin
      read_mux = pol;
    end else if (addr_is(c, REG_STATUS)) begin
      read_mux = stat;
    end else if (addr_is(c, REG_PTR_CTRL)) begin
      read_mux = ptr;
    end else if (addr_is(c, REG_FIFO_DATA)) begin
      read_mux = {head, 8'h00};
    end
  endfunction

  wire [15:0] first_word = read_mux(cmd_now, fifo_thr_q, pol_crc_q, status_word, ptr_word,
                                    fifo_head);

  // Serial access state machine, SPI mode 0, MSB first.
  always_comb begin
    state_d = state_q;
    cmd_d = cmd_q;
    cnt_d = cnt_q;
    sh_out_d = sh_out_q;
    hold_d = hold_q;
    if (ss_n_s) begin
      state_d = ST_CMD;
      cnt_d = 4'h0;
      hold_d = 1'b0;
    end else if (sck_rise) begin
      cnt_d = cnt_q + 4'h1;
      unique case (state_q)
        ST_CMD: begin
          if (cnt_q == CMD_LAST) begin
            state_d = ST_DATA;
            cmd_d = cmd_now;
            cnt_d = 4'h0;
            sh_out_d = cmd_now.rd ? first_word : 16'h0000;
            hold_d = 1'b1;
          end
        end
        ST_DATA: begin
          if (cnt_q == data_last) begin
            cnt_d = 4'h0;
            // Only the data port streams; other registers take one word.
            state_d = data_is_fifo ? ST_DATA : ST_SKIP;
            sh_out_d = 16'h0000;
            hold_d = 1'b0;
          end
        end
        ST_SKIP: begin
          cnt_d = 4'h0;
        end
      endcase
    end else if (reload_q) begin
      // The pop has just moved the head, so the next byte is taken a cycle later.
      sh_out_d = {fifo_head, 8'h00};
      hold_d = 1'b1;
    end else if (sck_fall) begin
      // A freshly loaded word keeps its first bit through this falling edge.
      hold_d = 1'b0;
      if (!hold_q) begin
        sh_out_d = {sh_out_q[14:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_CMD;
      cmd_q <= '0;
      cnt_q <= 4'h0;
      sh_in_q <= 16'h0000;
      sh_out_q <= 16'h0000;
      hold_q <= 1'b0;
      reload_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cmd_q <= cmd_d;
      cnt_q <= cnt_d;
      sh_out_q <= sh_out_d;
      hold_q <= hold_d;
      reload_q <= next_fifo_rd;
      if (sck_rise) begin
        sh_in_q <= in_word;
      end
    end
  end

  assign spi_miso = sh_out_q[15];
  assign spi_miso_oe_n = ss_n_s;

  // Configuration registers.
  // CRC seed register
  assign pol_crc_d = wr_pol ? (in_word & POL_CRC_WMASK) : pol_crc_q;
  assign fifo_thr_d = wr_thr ? in_word : fifo_thr_q;
  assign crc_seed = pol_crc_q[CRC_SEED_LSB +: DATA_W];

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pol_crc_q <= POL_CRC_RST;
      fifo_thr_q <= FIFO_THR_RST;
    end else begin
      pol_crc_q <= pol_crc_d;
      fifo_thr_q <= fifo_thr_d;
    end
  end

  // Sync indication lives only inside a receive.
  // sync bit
  wire sync_seen_d = rx_on & (sync_seen_q | eng_stat.sync_found);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sync_seen_q <= 1'b0;
    end else begin
      sync_seen_q <= sync_seen_d;
    end
  end

  // Flag pins and their status mirrors; the mirrors keep the active-high sense.
  // polarity applied
  wire pol_low = pol_crc_q[POL_BIT];

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pkt_mirror_q <= 1'b0;
      fifo_mirror_q <= 1'b0;
      packet_flag_mirror_q <= 1'b0;
      fifo_flag_q <= 1'b0;
    end else begin
      pkt_mirror_q <= eng_stat.packet_flag_mirror;
      fifo_mirror_q <= fifo_flag_raw;
      packet_flag_mirror_q <= eng_stat.packet_flag_mirror ^ pol_low;
      fifo_flag_q <= fifo_flag_raw ^ pol_low;
    end
  end

  assign packet_flag_mirror_pin = packet_flag_mirror_q;
  assign fifo_flag_pin = fifo_flag_q;

endmodule

`default_nettype wire

// File: ffs_top_chk.sv
`timescale 1ns/1ns
`default_nettype none
module ffs_top_chk
  import ffs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic spi_ss_n,
  input wire ffs_pkg::ffs_eng_stat_t eng_stat,
  input wire logic eng_rx_ready,
  input wire logic eng_tx_valid,
  input wire logic eng_tx_ready,
  input wire logic [ffs_pkg::DATA_W-1:0] eng_tx_data,
  input wire logic [ffs_pkg::DATA_W-1:0] crc_seed,
  input wire logic packet_flag_mirror_pin,
  input wire logic fifo_flag_pin
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  // Polarity is internal, so both pins are compared against each other instead.
  a_pkt_pin_follow: assert property (
    $changed(eng_stat.packet_flag_mirror) |=> packet_flag_mirror_pin != $past(packet_flag_mirror_pin))
    else $error("packet flag pin did not follow the engine flag");
  a_idle_flag_level: assert property (
    (!eng_stat.tx_active && !eng_stat.rx_active) [*2]
    |-> fifo_flag_pin == (packet_flag_mirror_pin ^ $past(eng_stat.packet_flag_mirror)))
    else $error("idle fifo flag pin differs from the polarity level");
  a_tx_empty_warn: assert property (
    eng_stat.tx_active && !eng_stat.rx_active && !eng_tx_valid
    |=> fifo_flag_pin != (packet_flag_mirror_pin ^ $past(eng_stat.packet_flag_mirror)))
    else $error("empty fifo in transmit gave no warning");
  a_rx_full_warn: assert property (
    eng_stat.rx_active && !eng_stat.tx_active && !eng_rx_ready
    |=> fifo_flag_pin != (packet_flag_mirror_pin ^ $past(eng_stat.packet_flag_mirror)))
    else $error("full fifo in receive gave no warning");
  a_rx_ready_own: assert property (
    eng_rx_ready |-> eng_stat.rx_active)
    else $error("engine push accepted outside receive");
  a_tx_valid_own: assert property (
    eng_tx_valid |-> eng_stat.tx_active)
    else $error("engine byte offered outside transmit");
  a_tx_head_hold: assert property (
    eng_tx_valid && !eng_tx_ready ##1 eng_stat.tx_active
    |-> eng_tx_valid && $stable(eng_tx_data))
    else $error("fifo head moved without a pop");
  a_seed_in_frame: assert property (
    $changed(crc_seed) |-> !spi_ss_n)
    else $error("crc seed changed outside a host frame");
endmodule
`default_nettype wire

// File: ffs_host.sv
`timescale 1ns/1ns
`default_nettype none
module ffs_host (
  input wire logic clk_sys,
  output logic spi_ss_n,
  output logic spi_sck,
  output logic spi_mosi,
  input wire logic spi_miso
);
  initial begin
    spi_ss_n = 1'h1;
    spi_sck = 1'h0;
    spi_mosi = 1'h0;
  end

  task automatic frame(input logic [7:0] cmd, input logic [31:0] wd, input int nb,
                       output logic [31:0] rd);
    logic [39:0] sh;
    sh = {cmd, wd << (32 - nb)};
    rd = 32'h0;
    @(posedge clk_sys);
    spi_ss_n <= 1'h0;
    for (int k = 0; k < 8 + nb; k++) begin
      spi_mosi <= sh[39];
      sh = sh << 1;
      repeat (5) @(posedge clk_sys);
      spi_sck <= 1'h1;
      if (k >= 8) begin
        rd = {rd[30:0], spi_miso};
      end
      repeat (5) @(posedge clk_sys);
      spi_sck <= 1'h0;
    end
    repeat (5) @(posedge clk_sys);
    spi_ss_n <= 1'h1;
    // A released line must not keep showing the last bit.
    spi_mosi <= ~spi_mosi;
    repeat (4) @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

// File: tb_ffs_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_ffs_top;
  import ffs_pkg::*;
  logic clk_sys, reset_n, ss_n, sck, mosi, miso, miso_oe_n;
  logic rx_valid, rx_ready, tx_valid, tx_ready, pkt_pin, fifo_pin;
  logic [DATA_W-1:0] rx_data, tx_data, seed;
  ffs_eng_stat_t es;
  logic [31:0] r;
  int fails = 0;
  int checks_done = 0;
  int cyc = 0;
  int i;

  ffs_top i_ffs_top (
    .clk_sys(clk_sys), .reset_n(reset_n), .spi_ss_n(ss_n), .spi_sck(sck), .spi_mosi(mosi),
    .spi_miso(miso), .spi_miso_oe_n(miso_oe_n), .eng_stat(es), .eng_rx_valid(rx_valid),
    .eng_rx_ready(rx_ready), .eng_rx_data(rx_data), .eng_tx_valid(tx_valid),
    .eng_tx_ready(tx_ready), .eng_tx_data(tx_data), .crc_seed(seed),
    .packet_flag_mirror_pin(pkt_pin), .fifo_flag_pin(fifo_pin)
  );
  ffs_host i_ffs_host (
    .clk_sys(clk_sys), .spi_ss_n(ss_n), .spi_sck(sck), .spi_mosi(mosi), .spi_miso(miso)
  );

  initial begin
    clk_sys = 1'h0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic final_report();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    i_ffs_host.frame({1'h0, a}, {16'h0000, d}, 16, r);
  endtask

  task automatic rd(input logic [6:0] a, input logic [15:0] e, input string n);
    i_ffs_host.frame({1'h1, a}, 32'h0, 16, r);
    chk(n, {16'h0000, e}, r);
  endtask

  task automatic push(input int n, input int b);
    for (int k = 0; k < n; k++) begin
      rx_valid <= 1'h1;
      rx_data <= 8'(b + k);
      @(posedge clk_sys);
    end
    rx_valid <= 1'h0;
  endtask

  // The run is about 5700 cycles; the ceiling leaves ample margin.
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 30000) begin
      fails++;
      final_report();
    end
  end

  initial begin
    reset_n = 1'h0;
    es = '0;
    rx_valid = 1'h0;
    rx_data = 8'h00;
    tx_ready = 1'h0;
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'h1;
    repeat (4) @(posedge clk_sys);
    rd(REG_POL_CRC, POL_CRC_RST, "polarity reset");
    rd(REG_FIFO_THR, FIFO_THR_RST, "threshold reset");
    chk("miso released", 32'h1, miso_oe_n);
    chk("seed reset", 32'h0, seed);
    wr(REG_POL_CRC, 16'h04A5);
    chk("seed", 32'hA5, seed);
    chk("packet pin low", 32'h1, pkt_pin);
    chk("fifo pin low", 32'h1, fifo_pin);
    rd(REG_POL_CRC, 16'h04A5, "polarity readback");
    wr(REG_POL_CRC, 16'h0000);
    chk("packet pin high", 32'h0, pkt_pin);
    es <= {1'h1, 1'h0, 6'h2A, 1'h1, 1'h1, 1'h0, 1'h1};
    rd(REG_STATUS, 16'hAAC0, "status in receive");
    es.rx_active <= 1'h0;
    rd(REG_STATUS, 16'hAA40, "status after receive");
    es <= '0;
    i_ffs_host.frame({1'h0, REG_FIFO_DATA}, 32'h112233, 24, r);
    rd(REG_PTR_CTRL, 16'h0303, "positions after write");
    i_ffs_host.frame({1'h1, REG_FIFO_DATA}, 32'h0, 16, r);
    chk("data port bytes", 32'h1122, r);
    rd(REG_PTR_CTRL, 16'h0301, "positions after read");
    wr(REG_PTR_CTRL, 16'h0000);
    rd(REG_PTR_CTRL, 16'h0301, "zero clear");
    es.rx_active <= 1'h1;
    wr(REG_PTR_CTRL, 16'h8000);
    es.rx_active <= 1'h0;
    rd(REG_PTR_CTRL, 16'h0301, "write clear in receive");
    es.tx_active <= 1'h1;
    wr(REG_PTR_CTRL, 16'h0080);
    chk("engine head valid", 32'h1, tx_valid);
    chk("engine head", 32'h33, tx_data);
    chk("almost empty", 32'h1, fifo_pin);
    rd(REG_PTR_CTRL, 16'h0301, "read clear in transmit");
    es.tx_active <= 1'h0;
    wr(REG_PTR_CTRL, 16'h8080);
    rd(REG_PTR_CTRL, 16'h0000, "both cleared");
    es.rx_active <= 1'h1;
    push(3, 0);
    repeat (2) @(posedge clk_sys);
    chk("below full threshold", 32'h0, fifo_pin);
    push(61, 3);
    repeat (2) @(posedge clk_sys);
    chk("full refuses", 32'h0, rx_ready);
    chk("almost full", 32'h1, fifo_pin);
    rd(REG_STATUS, 16'h0020, "fifo flag mirror");
    es.rx_active <= 1'h0;
    es.tx_active <= 1'h1;
    tx_ready <= 1'h1;
    i = 0;
    while (i < 64) begin
      @(posedge clk_sys);
      if (tx_valid === 1'h1 && tx_ready === 1'h1) begin
        chk("engine byte", i, tx_data);
        i++;
      end
    end
    tx_ready <= 1'h0;
    repeat (2) @(posedge clk_sys);
    chk("drained", 32'h0, tx_valid);
    chk("empty warning", 32'h1, fifo_pin);
    es <= '0;
    rd(7'h31, 16'h0000, "unmapped");
    reset_n <= 1'h0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'h1;
    repeat (4) @(posedge clk_sys);
    chk("miso released after reset", 32'h1, miso_oe_n);
    rd(REG_POL_CRC, POL_CRC_RST, "polarity after reset");
    final_report();
  end
endmodule

bind ffs_top ffs_top_chk i_ffs_top_chk (
  .clk_sys(clk_sys), .reset_n(reset_n), .spi_ss_n(spi_ss_n), .eng_stat(eng_stat),
  .eng_rx_ready(eng_rx_ready), .eng_tx_valid(eng_tx_valid), .eng_tx_ready(eng_tx_ready),
  .eng_tx_data(eng_tx_data), .crc_seed(crc_seed), .packet_flag_mirror_pin(packet_flag_mirror_pin),
  .fifo_flag_pin(fifo_flag_pin)
);
`default_nettype wire
